// >>> logic/isp_priority_bank.sv
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module isp_priority_bank #(
	parameter int NVEC = isp_pkg::NUM_VECTORS
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              cpuLevelHighBit,
	input  wire logic              cpuLevelLowBit,
	input  wire logic [NVEC-1:0]   vectorPending,
	input  wire logic              trapReq,
	output logic      [2*NVEC-1:0] vectorLevels,
	output logic      [NVEC-1:0]   vectorEligible,
	output logic                   topIrqTake,
	output logic                   trapTake
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Map a {hi,lo} code to a numeric rank 0..3
	function automatic logic [1:0] levelRank(input logic [1:0] code);
		logic [1:0] r;
		r = 2'h0;
		case (code)
			isp_pkg::LVL0_CODE: r = 2'h0;
			isp_pkg::LVL1_CODE: r = 2'h1;
			isp_pkg::LVL2_CODE: r = 2'h2;
			isp_pkg::LVL3_CODE: r = 2'h3;
			default:            r = 2'h0;
		endcase
		return r;
	endfunction

	// Match a byte offset against the bus address
	function automatic logic addrHit(input logic [11:0] a,
	                                 input logic [11:0] ofs);
		return a == ofs;
	endfunction

	// ------------------------------------------------------------
	// Bus request bundle and decode
	// ------------------------------------------------------------
	isp_pkg::isp_apb_req_s req;
	assign req = '{sel: psel, enable: penable, write: pwrite,
	               addr: paddr, wdata: pwdata};

	wire logic       hitReg0;
	wire logic       hitReg1;
	wire logic       hitReg2;
	wire logic       hitReg3;
	wire logic       hitCpu;
	wire logic       hitStat;
	wire logic       hitAny;
	wire logic       accessPh;
	wire logic       wrStrobe;
	wire logic [1:0] regIdx;
	wire logic       wrPrio;

	// Decode of the register word addresses
	assign hitReg0  = addrHit(req.addr, isp_pkg::PRIO_REG0_OFS);
	assign hitReg1  = addrHit(req.addr, isp_pkg::PRIO_REG1_OFS);
	assign hitReg2  = addrHit(req.addr, isp_pkg::PRIO_REG2_OFS);
	assign hitReg3  = addrHit(req.addr, isp_pkg::PRIO_REG3_OFS);
	assign hitCpu   = addrHit(req.addr, isp_pkg::CPU_LEVEL_OFS);
	assign hitStat  = addrHit(req.addr, isp_pkg::ARB_STAT_OFS);
	assign hitAny   = hitReg0 | hitReg1 | hitReg2 | hitReg3 | hitCpu |
	                  hitStat;
	assign accessPh = req.sel & req.enable;
	assign wrStrobe = accessPh & req.write & hitAny & pstrb[0];
	assign wrPrio   = wrStrobe & (hitReg0 | hitReg1 | hitReg2 | hitReg3);
	assign regIdx   = {hitReg2 | hitReg3, hitReg1 | hitReg3};

	// Zero-wait slave, unmapped addresses answer with an error
	assign pready   = 1'b1;
	assign pslverr  = accessPh & ~hitAny;

	// ------------------------------------------------------------
	// Priority register array
	// ------------------------------------------------------------
	logic [7:0] prioReg_r [isp_pkg::NUM_REGS];
	logic [7:0] prioByte;
	logic [7:0] filtered;

	assign prioByte = prioReg_r[regIdx];

	// Level-0 write filter applied pair by pair
	isp_pair_filter #(
		.PAIRS      (4)
	) uFilter (
		.oldByte    (prioByte),
		.newByte    (req.wdata[7:0]),
		.mergedByte (filtered)
	);

	// Register write; reset loads all ones
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < isp_pkg::NUM_REGS; i++) begin
				prioReg_r[i] <= isp_pkg::PRIO_RESET;
			end
		end else if (wrPrio) begin
			prioReg_r[regIdx] <= filtered;
		end
	end

	// ------------------------------------------------------------
	// Core level (condition-code mirror)
	// ------------------------------------------------------------
	logic [1:0] cpuLevel;
	assign cpuLevel = {cpuLevelHighBit, cpuLevelLowBit};

	// ------------------------------------------------------------
	// Vector level presentation
	// ------------------------------------------------------------
	wire logic [31:0] flatBank;

	// Fourth register upper nibble always reads ones
	assign flatBank = {isp_pkg::REG3_RO_BITS, prioReg_r[3][3:0],
	                   prioReg_r[2], prioReg_r[1], prioReg_r[0]};

	// Pairs ascend two bits per vector from bit 0 of the first register
	assign vectorLevels = flatBank[2*NVEC-1:0];

	// ------------------------------------------------------------
	// Arbitration qualifiers
	// ------------------------------------------------------------
	logic [NVEC-1:0] eligible;
	logic [1:0]      cpuRank;

	// A maskable vector may interrupt when its level exceeds the core's
	always_comb begin
		cpuRank  = levelRank(cpuLevel);
		eligible = '0;
		for (int v = 0; v < NVEC; v++) begin
			if (v == isp_pkg::TOP_IRQ_VEC) begin
				eligible[v] = vectorPending[v];
			end else if (cpuRank != 2'h3) begin
				eligible[v] = vectorPending[v] &
					(levelRank(vectorLevels[2*v+:2]) > cpuRank);
			end else begin
				eligible[v] = 1'b0;
			end
		end
	end

	assign vectorEligible = eligible;
	assign topIrqTake     = vectorPending[isp_pkg::TOP_IRQ_VEC];
	assign trapTake       = trapReq;

	// ------------------------------------------------------------
	// Read data path
	// ------------------------------------------------------------
	logic [31:0] rdMux;

	// Read multiplexer; unused upper bits read zero
	always_comb begin
		rdMux = 32'h0000_0000;
		if (hitReg0) rdMux = {24'h00_0000, flatBank[7:0]};
		if (hitReg1) rdMux = {24'h00_0000, flatBank[15:8]};
		if (hitReg2) rdMux = {24'h00_0000, flatBank[23:16]};
		if (hitReg3) rdMux = {24'h00_0000, flatBank[31:24]};
		if (hitCpu)  rdMux = {30'h0000_0000, cpuLevel};
		if (hitStat) rdMux = {{(32-NVEC){1'b0}}, eligible};
	end

	// Registered read data, loaded in the setup phase
	logic [31:0] prdata_r;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_r <= 32'h0000_0000;
		end else if (req.sel & ~req.enable & ~req.write) begin
			prdata_r <= rdMux;
		end
	end
	assign prdata = prdata_r;

endmodule
`default_nettype wire

// >>> common/isp_pkg.sv
package isp_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on APB)
	// ------------------------------------------------------------
	localparam logic [11:0] PRIO_REG0_OFS = 12'h000;
	localparam logic [11:0] PRIO_REG1_OFS = 12'h004;
	localparam logic [11:0] PRIO_REG2_OFS = 12'h008;
	localparam logic [11:0] PRIO_REG3_OFS = 12'h00C;
	localparam logic [11:0] CPU_LEVEL_OFS = 12'h010;
	localparam logic [11:0] ARB_STAT_OFS  = 12'h014;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int          NUM_REGS      = 4;
	localparam int          NUM_VECTORS   = 14;
	localparam int          TOP_IRQ_VEC   = 0;
	localparam logic [7:0]  PRIO_RESET    = 8'hFF;
	localparam logic [3:0]  REG3_RO_BITS  = 4'hF;
	localparam logic [1:0]  CPU_LVL_RESET = 2'h3;

	// ------------------------------------------------------------
	// Level codes: {high bit, low bit}
	// ------------------------------------------------------------
	localparam logic [1:0]  LVL0_CODE     = 2'h2;
	localparam logic [1:0]  LVL1_CODE     = 2'h1;
	localparam logic [1:0]  LVL2_CODE     = 2'h0;
	localparam logic [1:0]  LVL3_CODE     = 2'h3;

	// APB request carried as one bundle
	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [11:0] addr;
		logic [31:0] wdata;
	} isp_apb_req_s;

	// Pair of level bits
	typedef struct packed {
		logic hi;
		logic lo;
	} isp_level_s;

endpackage

// >>> logic/isp_pair_filter.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Per-pair write filter: level-0 code keeps the old pair
// ------------------------------------------------------------
module isp_pair_filter #(
	parameter int PAIRS = 4
) (
	input  wire logic [2*PAIRS-1:0] oldByte,
	input  wire logic [2*PAIRS-1:0] newByte,
	output logic      [2*PAIRS-1:0] mergedByte
);

	// Each pair chooses old contents when the written code is level 0
	genvar g;
	generate
		for (g = 0; g < PAIRS; g++) begin : gPair
			wire logic [1:0] wrPair;
			assign wrPair = newByte[2*g+1:2*g];
			assign mergedByte[2*g+1:2*g] = (wrPair == isp_pkg::LVL0_CODE) ?
				oldByte[2*g+1:2*g] : wrPair;
		end
	endgenerate

endmodule
`default_nettype wire

// >>> verif/isp_priority_bank_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Port checker for the priority bank
// ------------------------------------------------------------
module isp_priority_bank_chk #(
	parameter int NVEC = 14
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	input  wire logic [31:0]       prdata,
	input  wire logic              cpuLevelHighBit,
	input  wire logic              cpuLevelLowBit,
	input  wire logic [NVEC-1:0]   vectorPending,
	input  wire logic              trapReq,
	input  wire logic [2*NVEC-1:0] vectorLevels,
	input  wire logic [NVEC-1:0]   vectorEligible,
	input  wire logic              topIrqTake,
	input  wire logic              trapTake
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Completed write to the first register
	sequence s_wr0;
		psel && penable && pwrite && pstrb[0] && paddr == 12'h000;
	endsequence
	chk_reset_ones: assert property (!$past(rst_n) |-> &vectorLevels)
		else $error("levels not all ones after reset");
	chk_lvl0_keep: assert property (s_wr0 ##0 pwdata[1:0] == 2'h2
		|=> $stable(vectorLevels[1:0])) else $error("level 0 code stored");
	chk_write_land: assert property (s_wr0 ##0 pwdata[1:0] != 2'h2
		|=> vectorLevels[1:0] == $past(pwdata[1:0]))
		else $error("written pair not presented");
	chk_hold_idle: assert property (!(psel && penable && pwrite)
		|=> $stable(vectorLevels)) else $error("levels moved without write");
	chk_reg3_ro: assert property (psel && penable && !pwrite
		&& paddr == 12'h00C |-> prdata[7:4] == 4'hF)
		else $error("upper nibble of fourth register not ones");
	chk_top_pass: assert property (topIrqTake == vectorPending[0]
		&& trapTake == trapReq) else $error("top irq or trap blocked");
	chk_top_ignored: assert property (
		vectorEligible[0] == vectorPending[0])
		else $error("top irq eligibility uses its pair");
	chk_lvl3_block: assert property (cpuLevelHighBit && cpuLevelLowBit
		|-> vectorEligible[NVEC-1:1] == '0) else $error("level 3 not masking");
	chk_elig_rank: assert property (vectorPending[3]
		&& vectorLevels[7:6] == 2'h3 && !(cpuLevelHighBit && cpuLevelLowBit)
		|-> vectorEligible[3]) else $error("level 3 vector not eligible");
endmodule
bind isp_priority_bank isp_priority_bank_chk #(.NVEC(NVEC)) u_chk (
	.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .cpuLevelHighBit, .cpuLevelLowBit, .vectorPending, .trapReq,
	.vectorLevels, .vectorEligible, .topIrqTake, .trapTake
);
`default_nettype wire

// >>> verif/isp_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Core side: level bits and pending requests
// ------------------------------------------------------------
module isp_core_model (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [1:0]  levelReq,
	input  wire logic [13:0] pendReq,
	input  wire logic        trapIn,
	output logic             cpuLevelHighBit,
	output logic             cpuLevelLowBit,
	output logic      [13:0] vectorPending,
	output logic             trapReq
);
	// Core starts with interrupts disabled, then follows requests
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			{cpuLevelHighBit, cpuLevelLowBit} <= isp_pkg::LVL3_CODE;
			vectorPending <= 14'h0000;
			trapReq <= 1'b0;
		end else begin
			{cpuLevelHighBit, cpuLevelLowBit} <= levelReq;
			vectorPending <= pendReq;
			trapReq <= trapIn;
		end
	end
endmodule
`default_nettype wire

// >>> verif/test_interrupt_software_priority_bank.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Bench for the priority bank
// ------------------------------------------------------------
module test_interrupt_software_priority_bank;
	logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic        cpuLevelHighBit, cpuLevelLowBit, trapIn, trapReq;
	logic        topIrqTake, trapTake;
	logic [1:0]  levelReq;
	logic [3:0]  pstrb;
	logic [11:0] paddr;
	logic [13:0] pendReq, vectorPending, vectorEligible;
	logic [27:0] vectorLevels;
	logic [31:0] pwdata, prdata, rd;
	int          n_errors, samples_checked;
	isp_priority_bank u_isp_priority_bank (.mclk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
		.cpuLevelHighBit, .cpuLevelLowBit, .vectorPending, .trapReq,
		.vectorLevels, .vectorEligible, .topIrqTake, .trapTake);
	isp_core_model u_isp_core_model (.mclk, .rst_n, .levelReq, .pendReq,
		.trapIn, .cpuLevelHighBit, .cpuLevelLowBit, .vectorPending, .trapReq);
	// Clock generator, 40 ns period
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task print_verdict;
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			$display("mismatch %s expected %h seen %h", nm, ex, got);
			n_errors++;
		end
	endtask
	// One APB transfer: setup, access held until pready
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			n_errors++;
			print_verdict;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task t_reset;
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, 12'(4 * k), 32'h0);
			cmp("reset value", 32'h000000FF, rd);
		end
		cmp("reset levels", 32'h0FFFFFFF, {4'h0, vectorLevels});
	endtask
	task t_filter;
		apb(1'b1, 12'h000, 32'h000000CF);
		apb(1'b1, 12'h000, 32'h00000064);
		apb(1'b0, 12'h000, 32'h0);
		cmp("filtered", 32'h00000044, rd);
		apb(1'b1, 12'h000, 32'h00000046);
		apb(1'b0, 12'h000, 32'h0);
		cmp("kept pair", 32'h00000044, rd);
		cmp("levels 0-3", 32'h00000044, {24'h0, vectorLevels[7:0]});
	endtask
	task t_rw;
		apb(1'b1, 12'h00C, 32'h0000000D);
		apb(1'b1, 12'h008, 32'h00000055);
		apb(1'b0, 12'h00C, 32'h0);
		cmp("fourth reg", 32'h000000FD, rd);
		cmp("vector 12-13", 32'h0000000D, {28'h0, vectorLevels[27:24]});
		apb(1'b0, 12'h008, 32'h0);
		cmp("third reg", 32'h00000055, rd);
		apb(1'b1, 12'h020, 32'h0);
		cmp("unmapped err", 32'h1, {31'h0, err});
	endtask
	task t_elig;
		logic [1:0] codes [4];
		logic [13:0] ex;
		codes = '{2'h2, 2'h1, 2'h0, 2'h3};
		apb(1'b1, 12'h000, 32'h000000C7);
		for (int c = 0; c < 4; c++) begin
			levelReq <= codes[c];
			pendReq <= 14'h000F;
			trapIn <= (c == 3);
			repeat (2) @(posedge mclk);
			ex = 14'h0001;
			for (int k = 1; k < 4; k++)
				ex[k] = (k > c) && (c != 3);
			cmp("eligible", {18'h0, ex}, {18'h0, vectorEligible});
			cmp("top and trap", {30'h0, c == 3, 1'b1},
				{30'h0, trapTake, topIrqTake});
			// Core level and status words seen over the bus
			apb(1'b1, 12'h010, 32'h00000000);
			apb(1'b0, 12'h010, 32'h0);
			cmp("core level", {30'h0, codes[c]}, rd);
			apb(1'b0, 12'h014, 32'h0);
			cmp("status", {18'h0, ex}, rd);
		end
	endtask
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{psel, penable, pwrite, trapIn} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		levelReq = 2'h3;
		pendReq = 14'h0000;
		n_errors = 0;
		samples_checked = 0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset;
		t_filter;
		t_rw;
		t_elig;
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset;
		print_verdict;
	end
endmodule
`default_nettype wire
